/* logic/ddlc_top.sv */
// Notes on behaviour
// [R1] sample words are straight binary, bit 13 msb, bit 0 lsb
// [R2] all ones drives the true output to full scale
// [R3] complementary output carries full scale minus code
// [R4] capture is edge triggered, never transparent
// [R5] dual mode updates every clock rise, interleaved every other rise
// [R6] mode high gives two independent channels with own strobe and clock
// [R7] each channel holds an input latch feeding a separate dac latch
// [R8] dual mode: write rise loads input latch, clock rise loads dac latch
// [R9] source raises clock before write, or at least 2 ns after it
// [R10] mode low reassigns pins to write, clock, select and phase sync
// [R11] interleaved write rise steers word to latch 1 if select high, else 2
// [R12] source changes select only while write and clock are low
// [R13] phase sync high blocks the interleaved clock
// [R14] first clock rise after sync falls updates both, then every second
// [R15] source raises interleaved clock before or with interleaved write
`timescale 1ns/1ps
module ddlc_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic mode_dual,
  input ddlc_pkg::ddlc_port_type port1,
  input ddlc_pkg::ddlc_port_type port2,
  output ddlc_pkg::ddlc_out_type dac1,
  output ddlc_pkg::ddlc_out_type dac2
);
  import ddlc_pkg::*;

  // divider phase of the interleaved update clock
  typedef enum logic {
    ddlc_div_update,
    ddlc_div_skip
  } ddlc_div_type;

  // interleaved roles of the pins, sampled with their detected edges
  typedef struct packed {
    logic write_rise;
    logic clock_rise;
    logic select;
    logic sync;
    ddlc_word_type data;
  } ddlc_iq_type;

  // double buffer of one channel
  typedef struct packed {
    ddlc_word_type in_latch;
    ddlc_out_type dac_latch;
  } ddlc_chan_type;

  // all state of the block
  typedef struct packed {
    logic mode;
    ddlc_port_type port1_q;
    ddlc_port_type port2_q;
    ddlc_chan_type ch1;
    ddlc_chan_type ch2;
    ddlc_div_type phase;
  } ddlc_state_type;

  // converter drive through reset: code zero, complement at full scale
  localparam ddlc_out_type ddlc_out_reset = {ddlc_word_reset, ~ddlc_word_reset};

  ddlc_state_type state;
  ddlc_state_type next_state;
  ddlc_edge_type wr1_edge;
  ddlc_edge_type wr2_edge;
  ddlc_edge_type ck1_edge;
  ddlc_edge_type ck2_edge;
  ddlc_iq_type iq;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // converter drive: true code and its complement
  function automatic ddlc_out_type drive(input ddlc_word_type code);
    ddlc_out_type o;
    o.true_code = code; // [R1] [R2]
    o.comp_code = ~code; // [R3]
    return o;
  endfunction : drive

  // one channel in dual-port mode; a clock rise with a write takes the old word
  function automatic ddlc_chan_type dual_step(
    input ddlc_chan_type chan,
    input logic write_rise,
    input logic clock_rise,
    input ddlc_word_type data
  );
    ddlc_chan_type n;
    n = chan;
    if (clock_rise) begin
      n.dac_latch = drive(chan.in_latch); // [R7] [R5]
    end
    if (write_rise) begin
      n.in_latch = data; // [R8] [R4]
    end
    return n;
  endfunction : dual_step

  // interleaved mode: port1 strobe writes, port1 clock updates, port2 selects and syncs
  function automatic ddlc_iq_type iq_roles(
    input ddlc_edge_type write_edge,
    input ddlc_edge_type clock_edge,
    input ddlc_port_type data_port,
    input ddlc_port_type ctrl_port
  );
    ddlc_iq_type r;
    r.write_rise = write_edge.rise;
    r.clock_rise = clock_edge.rise;
    r.select = ctrl_port.write_strobe;
    r.sync = ctrl_port.update_clock;
    r.data = data_port.data;
    return r;
  endfunction : iq_roles

  // divide by two: an update rise is followed by a skipped rise
  function automatic ddlc_div_type div_next(input ddlc_div_type phase);
    ddlc_div_type n;
    case (phase)
      ddlc_div_update: n = ddlc_div_skip;
      ddlc_div_skip: n = ddlc_div_update;
      default: n = ddlc_div_update;
    endcase
    return n;
  endfunction : div_next

  ////////////////////////////////////////////////////////////////////////////
  // strobe edge detectors
  ddlc_edge u_wr1 (
    .clk(clk),
    .rstn(rstn),
    .level(port1.write_strobe),
    .edge_out(wr1_edge)
  );
  ddlc_edge u_wr2 (
    .clk(clk),
    .rstn(rstn),
    .level(port2.write_strobe),
    .edge_out(wr2_edge)
  );
  ddlc_edge u_ck1 (
    .clk(clk),
    .rstn(rstn),
    .level(port1.update_clock),
    .edge_out(ck1_edge)
  );
  ddlc_edge u_ck2 (
    .clk(clk),
    .rstn(rstn),
    .level(port2.update_clock),
    .edge_out(ck2_edge)
  );

  // pin roles in interleaved mode, aligned with the detected edges
  assign iq = iq_roles(wr1_edge, ck1_edge, state.port1_q, state.port2_q); // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // latch control
  always_comb begin
    next_state = state;
    // mode, data, select and sync delayed to align with the detected edges
    next_state.mode = mode_dual;
    next_state.port1_q = port1;
    next_state.port2_q = port2;
    if (state.mode == ddlc_mode_dual) begin // [R6]
      next_state.phase = ddlc_div_update;
      next_state.ch1 = dual_step(
        state.ch1,
        wr1_edge.rise,
        ck1_edge.rise,
        state.port1_q.data
      ); // [R8]
      next_state.ch2 = dual_step(
        state.ch2,
        wr2_edge.rise,
        ck2_edge.rise,
        state.port2_q.data
      ); // [R8]
    end else begin
      if (iq.write_rise) begin // [R10]
        if (iq.select == ddlc_sel_ch1) begin // [R11]
          next_state.ch1.in_latch = iq.data;
        end else begin
          next_state.ch2.in_latch = iq.data;
        end
      end
      if (iq.sync) begin
        next_state.phase = ddlc_div_update; // [R13]
      end else if (iq.clock_rise) begin
        next_state.phase = div_next(state.phase); // [R14]
        case (state.phase)
          ddlc_div_update: begin
            next_state.ch1.dac_latch = drive(state.ch1.in_latch); // [R5] [R14]
            next_state.ch2.dac_latch = drive(state.ch2.in_latch);
          end
          ddlc_div_skip: begin
            next_state.ch1.dac_latch = state.ch1.dac_latch;
            next_state.ch2.dac_latch = state.ch2.dac_latch;
          end
          default: begin
            next_state.phase = ddlc_div_update;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state.mode <= ddlc_mode_dual;
      state.port1_q <= '0;
      state.port2_q <= '0;
      state.ch1.in_latch <= ddlc_word_reset;
      state.ch1.dac_latch <= ddlc_out_reset;
      state.ch2.in_latch <= ddlc_word_reset;
      state.ch2.dac_latch <= ddlc_out_reset;
      state.phase <= ddlc_div_update;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign dac1 = state.ch1.dac_latch;
  assign dac2 = state.ch2.dac_latch;
endmodule : ddlc_top

/* logic/ddlc_pkg.sv */
package ddlc_pkg;
  localparam int DDLC_WIDTH = 14;
  localparam logic ddlc_mode_dual = 1'h1;
  localparam logic ddlc_sel_ch1 = 1'h1;
  localparam logic [13:0] ddlc_word_reset = 14'h0000;

  typedef logic [DDLC_WIDTH-1:0] ddlc_word_type;

  // pins of one port as the source drives them
  typedef struct packed {
    ddlc_word_type data;
    logic write_strobe;
    logic update_clock;
  } ddlc_port_type;

  // converter drive for one channel
  typedef struct packed {
    ddlc_word_type true_code;
    ddlc_word_type comp_code;
  } ddlc_out_type;

  // edge detector state for one strobe line
  typedef struct packed {
    logic last;
    logic rise;
  } ddlc_edge_type;
endpackage : ddlc_pkg

/* logic/ddlc_edge.sv */
`timescale 1ns/1ps
module ddlc_edge (
  input wire logic clk,
  input wire logic rstn,
  input wire logic level,
  output ddlc_pkg::ddlc_edge_type edge_out
);
  import ddlc_pkg::*;

  ddlc_edge_type state;
  ddlc_edge_type next_state;

  // rising edge detection, master/slave style
  always_comb begin
    next_state = state;
    next_state.last = level;
    next_state.rise = level & ~state.last;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign edge_out = state;
endmodule : ddlc_edge

/* verification/ddlc_props.sv */
`timescale 1ns/1ps
module ddlc_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic mode_dual,
  input ddlc_pkg::ddlc_port_type port1,
  input ddlc_pkg::ddlc_port_type port2,
  input ddlc_pkg::ddlc_out_type dac1,
  input ddlc_pkg::ddlc_out_type dac2
);
  import ddlc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence k1; $past(port1.update_clock, 2) && !$past(port1.update_clock, 3); endsequence
  sequence k2; $past(port2.update_clock, 2) && !$past(port2.update_clock, 3); endsequence
  AST_C1: assert property (dac1.comp_code == ~dac1.true_code) else $error("comp1");
  AST_C2: assert property (dac2.comp_code == ~dac2.true_code) else $error("comp2");
  AST_D1: assert property (mode_dual && $changed(dac1) |-> k1) else $error("dual1");
  AST_D2: assert property (mode_dual && $changed(dac2) |-> k2) else $error("dual2");
  AST_I1: assert property (!mode_dual && $changed(dac1) |-> k1) else $error("iq1");
  AST_I2: assert property (!mode_dual && $changed(dac2) |-> k1) else $error("iq2");
  AST_SY: assert property (!mode_dual && $changed(dac1) |-> !$past(port2.update_clock, 2))
    else $error("sync");
  AST_HD: assert property ($changed(dac1) |=> $stable(dac1)) else $error("hold");
  COV_D: cover property (mode_dual && $changed(dac2));
  COV_I: cover property (!mode_dual && $changed(dac2));
  COV_S: cover property (!mode_dual && port2.update_clock && port1.update_clock);
endmodule : ddlc_props
bind ddlc_top ddlc_props props (.clk, .rstn, .mode_dual, .port1, .port2, .dac1, .dac2);

/* verification/ddlc_src.sv */
`timescale 1ns/1ps
module ddlc_src (
  input wire logic clk,
  output ddlc_pkg::ddlc_port_type port1,
  output ddlc_pkg::ddlc_port_type port2
);
  import ddlc_pkg::*;
  initial port1 = '0;
  initial port2 = '0;
  // clock and write never overlap; released data is inverted
  task automatic pulse(input int p, input logic w, input ddlc_word_type d);
    @(negedge clk);
    if (p == 1) port1 = '{d, w, !w};
    else port2 = '{d, w, !w};
    @(negedge clk);
    if (p == 1) port1 = '{~d, 1'h0, 1'h0};
    else port2 = '{~d, 1'h0, 1'h0};
    repeat (3) @(negedge clk);
  endtask : pulse
  // called only while port1 strobes are low
  task automatic set(input logic sel, input logic sync);
    port2.write_strobe = sel;
    port2.update_clock = sync;
  endtask : set
endmodule : ddlc_src

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ddlc_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, mode_dual = 1'h1;
  ddlc_port_type port1, port2;
  ddlc_out_type dac1, dac2;
  int err_count = 0, n_tests = 0;
  always #5 clk = ~clk;
  ddlc_src src (.clk, .port1, .port2);
  ddlc_top dut (.clk, .rstn, .mode_dual, .port1, .port2, .dac1, .dac2);
  task automatic check(input ddlc_word_type s, input ddlc_word_type e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t %h %h", $time, s, e);
    end
  endtask : check
  task automatic close_out;
    $display("%0d errors %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic dual;
    src.pulse(1, 1'h1, 14'h3fff);
    src.pulse(2, 1'h1, 14'h0001);
    src.pulse(1, 1'h0, 14'h0);
    check(dac1.true_code, 14'h3fff);
    check(dac1.comp_code, 14'h0000);
    check(dac2.true_code, 14'h0);
    check(dac2.comp_code, 14'h3fff);
    src.pulse(2, 1'h0, 14'h0);
    check(dac2.true_code, 14'h0001);
  endtask : dual
  task automatic iq;
    mode_dual = 1'h0;
    src.set(1'h1, 1'h1);
    src.pulse(1, 1'h1, 14'h0aaa);
    src.set(1'h0, 1'h1);
    src.pulse(1, 1'h1, 14'h0555);
    src.pulse(1, 1'h0, 14'h0);
    check(dac1.true_code, 14'h3fff);
    check(dac2.true_code, 14'h0001);
    src.set(1'h1, 1'h0);
    src.pulse(1, 1'h0, 14'h0);
    check(dac1.true_code, 14'h0aaa);
    check(dac2.true_code, 14'h0555);
    check(dac2.comp_code, 14'h3aaa);
    src.pulse(1, 1'h1, 14'h0123);
    src.pulse(1, 1'h0, 14'h0);
    check(dac1.true_code, 14'h0aaa);
    src.pulse(1, 1'h0, 14'h0);
    check(dac1.true_code, 14'h0123);
  endtask : iq
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    dual();
    iq();
    close_out();
  end
  initial begin
    #5000;
    err_count++;
    close_out();
  end
endmodule : testbench
